/* design/dlbp_pkg.sv */
package dlbp_pkg;
    // register byte offsets
    localparam logic [7:0] DLBP_OFS_POLICER_CONFIG   = 8'h00;
    localparam logic [7:0] DLBP_OFS_COMMITTED_BUCKET = 8'h04;
    localparam logic [7:0] DLBP_OFS_EXCESS_BUCKET    = 8'h08;
    localparam logic [7:0] DLBP_OFS_GLOBAL_CTRL      = 8'h0c;
    localparam logic [7:0] DLBP_OFS_STICKY           = 8'h10;
    localparam logic [7:0] DLBP_OFS_COMMITTED_LEVEL  = 8'h14;
    localparam logic [7:0] DLBP_OFS_EXCESS_LEVEL     = 8'h18;

    // policer_config field positions
    localparam int DLBP_CFG_LIMIT_LSB    = 0;
    localparam int DLBP_CFG_COUPLE_BIT   = 2;
    localparam int DLBP_CFG_INC_LSB      = 3;
    localparam int DLBP_CFG_ADJ_LSB      = 5;
    localparam int DLBP_CFG_GRAN_LSB     = 12;
    localparam int DLBP_CFG_TTYPE_LSB    = 14;
    // bucket_config field positions
    localparam int DLBP_BKT_BURST_LSB    = 0;
    localparam int DLBP_BKT_RATE_LSB     = 16;
    // global control field positions
    localparam int DLBP_GC_DRAIN_BIT     = 0;
    localparam int DLBP_GC_FILL_BIT      = 1;
    localparam int DLBP_GC_TICKS_LSB     = 4;
    // sticky flag positions
    localparam int DLBP_ST_DROP_BIT      = 0;
    localparam int DLBP_ST_WITHIN_BIT    = 1;
    localparam int DLBP_ST_COMMIT_BIT    = 2;
    localparam int DLBP_ST_PEAK_BIT      = 3;

    // widths
    localparam int DLBP_LVL_W            = 20;
    localparam int DLBP_LEN_W            = 14;
    localparam int DLBP_TICK_W           = 12;
    localparam int DLBP_BURST_SHIFT      = 11;   // 2 kilobyte unit

    // named constants; reset does not use them and clears every register to zero
    localparam logic [1:0]  DLBP_RST_GREEN_LIMIT = 2'h3;
    localparam logic [1:0]  DLBP_RST_TTYPE       = 2'h3;
    localparam logic [11:0] DLBP_RST_TICKS       = 12'h001;
    localparam logic [1:0]  DLBP_COLOUR_BLIND    = 2'h3;
    localparam logic [1:0]  DLBP_DP_MAX          = 2'h3;

    typedef struct packed {
        logic [1:0]            requested_drop_precedence;
        logic [DLBP_LEN_W-1:0] length;
        logic                  to_cpu;
        logic                  to_front;
    } dlbp_frame_s;

    typedef struct packed {
        logic [1:0] drop_precedence;
        logic       yellow;
        logic       drop;
        logic       policed;
    } dlbp_result_s;
endpackage

/* design/dlbp_policer.sv */
// Behaviour
// RL1: frame with drop precedence at or below green_dp_limit is green, above is yellow
// RL2: green_dp_limit of 3 makes every frame green, colour-blind
// RL3: uncoupled: software loads committed rate/burst and excess rate/burst
// RL4: coupled: software loads committed, and excess plus committed into second bucket
// RL5: committed rate exceeded raises drop precedence by excess_dp_increment
// RL6: signed 7-bit frame_size_adjust corrects counted frame length
// RL7: burst limits are 7 bits in 2 kilobyte units, up to 254 kilobytes
// RL8: drain rates are 11 bits, 2048 steps, scaled by granularity
// RL9: traffic type selects processor frames, front port frames, or both
// RL10: policing runs only with global drain and fill enables both set
// RL11: rate_unit_ticks sets the base tick and so every rate step
// RL12: rate_granularity_sel selects each rate's granularity
// RL13: dropping a frame sets a sticky drop flag until cleared
// RL14: sticky flags for within rates, committed exceeded and peak exceeded
// RL15: frame size adjust ranges minus 64 to plus 63 bytes per frame
// RL16: buckets drain per base tick, fill by adjusted length; over excess drops
// RL17: sticky flags clear by writing one, otherwise stay set
`timescale 1ns/1ps
module dlbp_policer
    import dlbp_pkg::*;
(
    input  wire logic         pclk,        // bus and policer clock
    input  wire logic         presetn,     // asynchronous reset, active low
    input  wire logic         psel,        // apb select
    input  wire logic         penable,     // apb access phase
    input  wire logic         pwrite,      // apb direction
    input  wire logic [7:0]   paddr,       // apb byte address
    input  wire logic [31:0]  pwdata,      // apb write data
    output logic [31:0]       prdata,      // apb read data
    output logic              pready,      // apb ready
    output logic              pslverr,     // apb error, unmapped address
    input  wire logic         frame_valid, // frame decision request
    input  wire dlbp_frame_s  frame_in,    // frame attributes
    output logic              result_valid,// decision pulse
    output dlbp_result_s      result       // decision
);

    // configuration, sticky, level and tick registers
    logic [31:0]             policer_config;
    logic [31:0]             committed_bucket_config;
    logic [31:0]             excess_bucket_config;
    logic [31:0]             global_ctrl;
    logic [3:0]              sticky;
    logic [DLBP_LVL_W-1:0]   lvl_c;
    logic [DLBP_LVL_W-1:0]   lvl_e;
    logic [DLBP_TICK_W-1:0]  tick_cnt;
    logic                    base_tick;

    // decoded fields
    logic [1:0]              green_dp_limit;
    logic                    coupling_sel;
    logic [1:0]              excess_dp_increment;
    logic [6:0]              frame_size_adjust;
    logic [1:0]              rate_granularity_sel;
    logic [1:0]              traffic_type_sel;
    logic [6:0]              burst_c;
    logic [6:0]              burst_e;
    logic [10:0]             rate_c;
    logic [10:0]             rate_e;
    logic                    global_drain_enable;
    logic                    global_fill_enable;
    logic [DLBP_TICK_W-1:0]  rate_unit_ticks;

    assign green_dp_limit       = policer_config[DLBP_CFG_LIMIT_LSB +: 2];
    assign coupling_sel         = policer_config[DLBP_CFG_COUPLE_BIT];
    assign excess_dp_increment  = policer_config[DLBP_CFG_INC_LSB +: 2];
    assign frame_size_adjust    = policer_config[DLBP_CFG_ADJ_LSB +: 7];
    assign rate_granularity_sel = policer_config[DLBP_CFG_GRAN_LSB +: 2];
    assign traffic_type_sel     = policer_config[DLBP_CFG_TTYPE_LSB +: 2];
    assign burst_c              = committed_bucket_config[DLBP_BKT_BURST_LSB +: 7];
    assign burst_e              = excess_bucket_config[DLBP_BKT_BURST_LSB +: 7];
    assign rate_c               = committed_bucket_config[DLBP_BKT_RATE_LSB +: 11];
    assign rate_e               = excess_bucket_config[DLBP_BKT_RATE_LSB +: 11];
    assign global_drain_enable  = global_ctrl[DLBP_GC_DRAIN_BIT];
    assign global_fill_enable   = global_ctrl[DLBP_GC_FILL_BIT];
    assign rate_unit_ticks      = global_ctrl[DLBP_GC_TICKS_LSB +: DLBP_TICK_W];

    // apb decode
    logic wr_acc;
    logic rd_setup;
    logic addr_hit;

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    always_comb begin
        case (paddr)
            DLBP_OFS_POLICER_CONFIG,
            DLBP_OFS_COMMITTED_BUCKET,
            DLBP_OFS_EXCESS_BUCKET,
            DLBP_OFS_GLOBAL_CTRL,
            DLBP_OFS_STICKY,
            DLBP_OFS_COMMITTED_LEVEL,
            DLBP_OFS_EXCESS_LEVEL:     addr_hit = 1'b1;
            default:                   addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            policer_config          <= 32'h0;
            committed_bucket_config <= 32'h0;
            excess_bucket_config    <= 32'h0;
            global_ctrl             <= 32'h0;
        end else if (wr_acc) begin
            case (paddr)
                DLBP_OFS_POLICER_CONFIG:   policer_config <= {16'h0, pwdata[15:0]};
                DLBP_OFS_COMMITTED_BUCKET: committed_bucket_config <=
                    {5'h0, pwdata[26:16], 9'h0, pwdata[6:0]}; // [RL7] [RL8]
                DLBP_OFS_EXCESS_BUCKET:    excess_bucket_config <=
                    {5'h0, pwdata[26:16], 9'h0, pwdata[6:0]}; // [RL7] [RL8]
                DLBP_OFS_GLOBAL_CTRL:      global_ctrl <= {16'h0, pwdata[15:4], 2'h0, pwdata[1:0]};
                default: ;
            endcase
        end
    end

    // read data sampled in setup so it comes from flops in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            case (paddr)
                DLBP_OFS_POLICER_CONFIG:   prdata <= policer_config;
                DLBP_OFS_COMMITTED_BUCKET: prdata <= committed_bucket_config;
                DLBP_OFS_EXCESS_BUCKET:    prdata <= excess_bucket_config;
                DLBP_OFS_GLOBAL_CTRL:      prdata <= global_ctrl;
                DLBP_OFS_STICKY:           prdata <= {28'h0, sticky};
                DLBP_OFS_COMMITTED_LEVEL:  prdata <= {12'h0, lvl_c};
                DLBP_OFS_EXCESS_LEVEL:     prdata <= {12'h0, lvl_e};
                default:                   prdata <= 32'h0;
            endcase
        end
    end

    // base tick; zero count treated as one so the buckets still drain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt  <= 12'h0;
            base_tick <= 1'b0;
        end else if (tick_cnt + 12'h1 >= rate_unit_ticks) begin // [RL11]
            tick_cnt  <= 12'h0;
            base_tick <= 1'b1;
        end else begin
            tick_cnt  <= tick_cnt + 12'h1;
            base_tick <= 1'b0;
        end
    end

    // drain amount per tick: rate scaled by 4 to the power of granularity
    logic [DLBP_LVL_W-1:0] drain_c;
    logic [DLBP_LVL_W-1:0] drain_e;
    logic [4:0]            gran_shift;

    assign gran_shift = {2'h0, rate_granularity_sel, 1'b0}; // [RL12]
    assign drain_c    = DLBP_LVL_W'({9'h0, rate_c} << gran_shift); // [RL8]
    assign drain_e    = DLBP_LVL_W'({9'h0, rate_e} << gran_shift); // [RL8]

    // burst limits in bytes
    logic [DLBP_LVL_W-1:0] limit_c;
    logic [DLBP_LVL_W-1:0] limit_e;

    assign limit_c = DLBP_LVL_W'({13'h0, burst_c} << DLBP_BURST_SHIFT); // [RL7]
    assign limit_e = DLBP_LVL_W'({13'h0, burst_e} << DLBP_BURST_SHIFT); // [RL7]

    // policing enables
    logic active;
    logic type_match;
    logic do_police;

    assign active     = global_drain_enable & global_fill_enable; // [RL10]
    assign type_match = (frame_in.to_cpu & traffic_type_sel[0]) |
                        (frame_in.to_front & traffic_type_sel[1]); // [RL9]
    assign do_police  = frame_valid & active & type_match;

    // adjusted length, clamped at zero
    logic signed [DLBP_LEN_W+1:0] adj_sum;
    logic [DLBP_LVL_W-1:0]        adj_len;

    assign adj_sum = $signed({2'b00, frame_in.length}) +
                     (DLBP_LEN_W+2)'($signed(frame_size_adjust)); // [RL6] [RL15]
    assign adj_len = adj_sum[DLBP_LEN_W+1] ? '0 :
                     DLBP_LVL_W'(adj_sum[DLBP_LEN_W:0]);

    // levels after this cycle's drain
    logic [DLBP_LVL_W-1:0] drained_c;
    logic [DLBP_LVL_W-1:0] drained_e;

    always_comb begin
        drained_c = lvl_c;
        drained_e = lvl_e;
        if (base_tick && global_drain_enable) begin // [RL16]
            drained_c = (lvl_c > drain_c) ? lvl_c - drain_c : '0;
            drained_e = (lvl_e > drain_e) ? lvl_e - drain_e : '0;
        end
    end

    // colour and bucket checks
    logic                  is_green;
    logic                  fit_c;
    logic                  fit_e;
    logic [DLBP_LVL_W:0]   sum_c;
    logic [DLBP_LVL_W:0]   sum_e;

    assign is_green = (green_dp_limit == DLBP_COLOUR_BLIND) ||            // [RL2]
                      (frame_in.requested_drop_precedence <= green_dp_limit); // [RL1]
    assign sum_c    = {1'b0, drained_c} + {1'b0, adj_len};
    assign sum_e    = {1'b0, drained_e} + {1'b0, adj_len};
    assign fit_c    = sum_c <= {1'b0, limit_c};
    assign fit_e    = sum_e <= {1'b0, limit_e};

    logic pass_green;
    logic pass_yellow;
    logic drop_frame;
    logic commit_over;

    assign pass_green  = do_police & is_green & fit_c;
    assign commit_over = do_police & is_green & ~fit_c;
    assign pass_yellow = do_police & ~fit_c & fit_e | do_police & ~is_green & fit_e;
    assign drop_frame  = do_police & ~pass_green & ~fit_e; // [RL16]

    // bucket updates; coupled mode also charges green bytes to the second bucket when they fit there
    logic [DLBP_LVL_W-1:0] next_lvl_c;
    logic [DLBP_LVL_W-1:0] next_lvl_e;

    always_comb begin
        next_lvl_c = drained_c;
        next_lvl_e = drained_e;
        if (pass_green) begin // [RL16]
            next_lvl_c = sum_c[DLBP_LVL_W-1:0];
            if (coupling_sel && fit_e) begin // [RL4]
                next_lvl_e = sum_e[DLBP_LVL_W-1:0];
            end
        end else if (pass_yellow) begin // [RL16] [RL3]
            next_lvl_e = sum_e[DLBP_LVL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_c <= '0;
            lvl_e <= '0;
        end else begin
            lvl_c <= next_lvl_c;
            lvl_e <= next_lvl_e;
        end
    end

    // raised drop precedence, saturating
    logic [2:0] dp_sum;
    logic [1:0] dp_out;

    assign dp_sum = {1'b0, frame_in.requested_drop_precedence} + {1'b0, excess_dp_increment};
    always_comb begin
        dp_out = frame_in.requested_drop_precedence;
        if (pass_yellow && is_green) begin // [RL5]
            dp_out = dp_sum[2] ? DLBP_DP_MAX : dp_sum[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_valid <= 1'b0;
            result       <= '0;
        end else begin
            result_valid <= frame_valid;
            // fields hold between pulses so a slow reader sees the last decision
            if (frame_valid) begin
                result.drop_precedence <= dp_out;
                result.yellow          <= do_police & ~pass_green & ~drop_frame;
                result.drop            <= drop_frame; // [RL16]
                result.policed         <= do_police;
            end
        end
    end

    // sticky flags: an event in the clearing cycle wins over the clear
    logic [3:0] set_flags;
    logic [3:0] clr_flags;

    assign set_flags[DLBP_ST_DROP_BIT]   = drop_frame;               // [RL13]
    assign set_flags[DLBP_ST_WITHIN_BIT] = pass_green;               // [RL14]
    assign set_flags[DLBP_ST_COMMIT_BIT] = commit_over;              // [RL14]
    assign set_flags[DLBP_ST_PEAK_BIT]   = do_police & ~fit_e & ~pass_green; // [RL14]
    assign clr_flags = (wr_acc && paddr == DLBP_OFS_STICKY) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sticky <= 4'h0;
        end else begin
            sticky <= (sticky & ~clr_flags) | set_flags; // [RL17] [RL13]
        end
    end

endmodule

/* dv/dlbp_policer_monitor.sv */
`timescale 1ns/1ps
module dlbp_policer_monitor
    import dlbp_pkg::*;
(
    input wire logic         pclk,         // clock
    input wire logic         presetn,      // reset
    input wire logic         psel,         // select
    input wire logic         penable,      // access
    input wire logic         pwrite,       // direction
    input wire logic [7:0]   paddr,        // address
    input wire logic [31:0]  pwdata,       // write data
    input wire logic [31:0]  prdata,       // read data
    input wire logic         pready,       // ready
    input wire logic         pslverr,      // error
    input wire logic         frame_valid,  // request
    input wire dlbp_frame_s  frame_in,     // frame
    input wire logic         result_valid, // answer
    input wire dlbp_result_s result        // decision
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    a_zero_wait: assert property (acc |-> pready) else $error("access stalled");
    a_err_map: assert property (acc |-> pslverr == !hit) else $error("pslverr wrong");
    a_err_phase: assert property (pslverr |-> acc) else $error("pslverr outside access");
    a_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved");
    a_result_next: assert property (frame_valid |=> result_valid) else $error("no result");
    a_result_only: assert property (!frame_valid |=> !result_valid)
        else $error("result without frame");
    // result is read by software-side logic at any time between pulses
    a_result_hold: assert property (!result_valid |-> $stable(result))
        else $error("result moved");
    a_dp_floor: assert property (result_valid && result.policed |->
        result.drop_precedence >= $past(frame_in.requested_drop_precedence))
        else $error("precedence lowered");
    a_green_keep: assert property (result_valid && !result.yellow && !result.drop |->
        result.drop_precedence == $past(frame_in.requested_drop_precedence))
        else $error("green precedence changed");
    a_bypass_clean: assert property (result_valid && !result.policed |->
        !result.drop && !result.yellow) else $error("unpoliced frame altered");
    a_no_dest: assert property (frame_valid && !(frame_in.to_cpu || frame_in.to_front) |=>
        !result.policed) else $error("frame without destination policed");
    c_drop: cover property (result_valid && result.drop);
    c_yellow: cover property (result_valid && result.yellow && !result.drop);
    c_err: cover property (acc && pslverr);
endmodule
bind dlbp_policer dlbp_policer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid), .frame_in(frame_in),
    .result_valid(result_valid), .result(result));

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench
    import dlbp_pkg::*;
;
    localparam logic [7:0] r_cfg = DLBP_OFS_POLICER_CONFIG;
    localparam logic [7:0] r_cb = DLBP_OFS_COMMITTED_BUCKET;
    localparam logic [7:0] r_eb = DLBP_OFS_EXCESS_BUCKET;
    localparam logic [7:0] r_gc = DLBP_OFS_GLOBAL_CTRL;
    localparam logic [7:0] r_st = DLBP_OFS_STICKY;
    localparam logic [7:0] r_cl = DLBP_OFS_COMMITTED_LEVEL;
    localparam logic [7:0] r_el = DLBP_OFS_EXCESS_LEVEL;
    logic         pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, q;
    logic         pready, pslverr, e, result_valid, frame_valid = 1'h0;
    dlbp_frame_s  frame_in = '0;
    dlbp_result_s result;
    int           bad_count = 0, compares = 0;
    always #12.5 pclk = ~pclk;
    dlbp_policer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_valid(frame_valid), .frame_in(frame_in),
        .result_valid(result_valid), .result(result));
    function automatic logic [31:0] pc(logic [1:0] lim, logic cpl, logic [1:0] inc,
        logic [6:0] adj, logic [1:0] gr, logic [1:0] tt);
        return {16'h0, tt, gr, adj, inc, cpl, lim};
    endfunction
    function automatic logic [31:0] bk(logic [6:0] burst, logic [10:0] rate);
        return {5'h0, rate, 9'h0, burst};
    endfunction
    function automatic logic [31:0] gc(logic fill, logic drain, logic [11:0] ticks);
        return {16'h0, ticks, 2'h0, fill, drain};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(n, q, x);
    endtask
    // dst is {to_cpu, to_front}; result is sampled mid-cycle of its pulse
    task automatic frm(input logic [1:0] dp, input logic [13:0] len, input logic [1:0] dst);
        @(posedge pclk);
        frame_valid <= 1'h1;
        frame_in <= '{dp, len, dst[1], dst[0]};
        @(posedge pclk);
        frame_valid <= 1'h0;
        @(negedge pclk);
        chk("result_valid", result_valid, 1'h1);
    endtask
    task automatic rst();
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
    endtask
    task automatic base();
        rst();
        wr(r_gc, gc(1'h1, 1'h1, 12'h0));
        wr(r_cb, bk(7'h7f, 11'h0));
        wr(r_eb, bk(7'h7f, 11'h0));
    endtask
    task automatic t_regs();
        rd("sticky", r_st, 32'h0);
        rd("level", r_cl, 32'h0);
        wr(r_cfg, 32'hffff_ffff);
        rd("config", r_cfg, 32'h0000_ffff);
        wr(r_eb, 32'hffff_ffff);
        rd("bucket", r_eb, 32'h07ff_007f);
        wr(r_gc, 32'hffff_ffff);
        rd("global", r_gc, 32'h0000_fff3);
        rd("unmapped", 8'h1c, 32'h0);
        chk("pslverr", e, 1'h1);
        wr(r_el, 32'hffff_ffff);
        rd("ro level", r_el, 32'h0);
        chk("pslverr", e, 1'h0);
    endtask
    task automatic t_gate();
        rst();
        wr(r_cfg, pc(2'h3, 1'h0, 2'h0, 7'h0, 2'h0, 2'h3));
        for (int g = 0; g < 4; g++) begin
            wr(r_gc, gc(g[1], g[0], 12'h0));
            frm(2'h1, 14'h40, 2'h3);
            chk("drop", {result.drop, result.policed}, {g == 3, g == 3});
        end
        rd("sticky", r_st, 32'hd);
        wr(r_st, 32'h1);
        rd("sticky", r_st, 32'hc);
        wr(r_st, 32'h0);
        rd("sticky", r_st, 32'hc);
    endtask
    task automatic t_colour();
        base();
        for (int l = 0; l < 4; l++) begin
            wr(r_cfg, pc(l[1:0], 1'h0, 2'h0, 7'h0, 2'h0, 2'h3));
            for (int d = 0; d < 4; d++) begin
                frm(d[1:0], 14'h40, 2'h3);
                chk("colour", result, {d[1:0], d > l && l < 3, 2'h1});
            end
        end
        rd("sticky", r_st, 32'h2);
    endtask
    task automatic t_exceed();
        base();
        wr(r_cb, bk(7'h0, 11'h0));
        wr(r_eb, bk(7'h1, 11'h0));
        for (int i = 0; i < 4; i++) begin
            wr(r_cfg, pc(2'h3, 1'h0, i[1:0], 7'h0, 2'h0, 2'h3));
            frm(2'h1, 14'h40, 2'h3);
            chk("raised dp", result, {(i >= 2) ? 2'h3 : 2'(i + 1), 3'h5});
        end
        rd("excess level", r_el, 32'h100);
        frm(2'h0, 14'h700, 2'h3);
        chk("full fit", result, {2'h3, 3'h5});
        frm(2'h0, 14'h1, 2'h3);
        chk("dropped", result[1:0], 2'h3);
        rd("sticky", r_st, 32'hd);
    endtask
    task automatic t_adjust();
        base();
        wr(r_cfg, pc(2'h3, 1'h0, 2'h0, 7'h40, 2'h0, 2'h3));
        frm(2'h0, 14'h64, 2'h3);
        rd("level", r_cl, 32'h24);
        wr(r_cfg, pc(2'h3, 1'h0, 2'h0, 7'h3f, 2'h0, 2'h3));
        frm(2'h0, 14'h64, 2'h3);
        rd("level", r_cl, 32'hc7);
        rd("uncoupled", r_el, 32'h0);
        wr(r_cfg, pc(2'h3, 1'h1, 2'h0, 7'h0, 2'h0, 2'h3));
        frm(2'h0, 14'h64, 2'h3);
        rd("coupled", r_el, 32'h64);
    endtask
    task automatic t_drain();
        base();
        wr(r_cfg, pc(2'h3, 1'h0, 2'h0, 7'h0, 2'h0, 2'h3));
        frm(2'h0, 14'h3e8, 2'h3);
        wr(r_gc, gc(1'h1, 1'h0, 12'ha));
        wr(r_cb, bk(7'h7f, 11'h1));
        repeat (100) @(posedge pclk);
        rd("held", r_cl, 32'h3e8);
        wr(r_gc, gc(1'h1, 1'h1, 12'ha));
        repeat (100) @(posedge pclk);
        apb(1'h0, r_cl, 32'h0);
        chk("slow drain", q >= 32'h3d4 && q <= 32'h3e3, 1'h1);
        wr(r_cfg, pc(2'h3, 1'h0, 2'h0, 7'h0, 2'h3, 2'h3));
        repeat (200) @(posedge pclk);
        rd("fast drain", r_cl, 32'h0);
    endtask
    task automatic t_ttype();
        base();
        for (int t = 0; t < 4; t++) begin
            wr(r_cfg, pc(2'h3, 1'h0, 2'h0, 7'h0, 2'h0, t[1:0]));
            for (int k = 0; k < 3; k++) begin
                frm(2'h0, 14'h40, k[1:0]);
                chk("policed", result.policed, k == 2 ? t[0] : (k == 1 && t[1]));
            end
        end
    endtask
    initial begin
        rst();
        t_regs();
        t_gate();
        t_colour();
        t_exceed();
        t_adjust();
        t_drain();
        t_ttype();
        finish_test();
    end
endmodule
